// File: design/ttp_regs.svh
// How it works
// RL1: irq flag follows transmit-empty or receive-full
// RL2: status read clears irq flag
// RL3: burst pause end sets transmit-empty
// RL4: status read or non-burst clears transmit-empty
// RL5: held received digit sets receive-full
// RL6: status read clears receive-full
// RL7: valid tone absence sets delayed_steer_flag
// RL8: valid tone pair clears delayed_steer_flag
// RL9: host waits 100ms then resets; testbench waits 10 clock cycles after rst_n rises
// RL10: host reset: read, writes 0,0,0,8,0, read
// RL11: select high control/status, low data
// RL12: host burst setup writes a then b
// RL13: burst is 50 ms tone, 50 ms pause
// RL14: transmit-empty 100 ms after digit write
// RL15: extended burst doubles delay to 200 ms
// RL16: host waits irq or polls status
// RL17: host writes next digit when b1 set
// RL18: host reads receive data when b2 set
// RL19: select bit steers next write to b
// RL20: irq pin pulls low on events
// RL21: burst active while control b bit0 low
// RL22: status read releases irq pin
// RL23: intervals counted in clock cycles
`ifndef TTP_REGS_SVH
`define TTP_REGS_SVH
// ==========================================
// bit positions
`define TTP_ST_IRQ 0
`define TTP_ST_TXE 1
`define TTP_ST_RXF 2
`define TTP_ST_STEER 3
`define TTP_CA_TONE 0
`define TTP_CA_CP 1
`define TTP_CA_IRQEN 2
`define TTP_CA_NEXT_SEL 3
`define TTP_CB_NOBURST 0
`define TTP_CB_TEST 1
// ==========================================
// reset values
`define TTP_CTRL_RST 4'h0
`define TTP_STAT_RST 4'h0
// ==========================================
// timing
`define TTP_CLK_KHZ 20000
`define TTP_BURST_MS 50
`define TTP_BURST_CYC (`TTP_BURST_MS * `TTP_CLK_KHZ)
`endif

// File: design/ttp_pkg.sv
package ttp_pkg;
  typedef struct packed {
    logic rs;
    logic rd_n;
    logic wr_n;
    logic [3:0] data;
    logic cp_wave;
  } ttp_pins_t;

  typedef struct packed {
    logic steer;
    logic rx_full;
    logic tx_empty;
    logic irq;
  } ttp_status_t;

  typedef enum logic [1:0] {
    TTP_IDLE,
    TTP_TONE,
    TTP_PAUSE
  } ttp_tx_state_t;
endpackage

// File: design/ttp_host_port.sv
`timescale 1ns/1ns
`include "ttp_regs.svh"

// ==========================================
// receive digit buffer
module ttp_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
        in_ready <= (count_q != (AW+1)'(DEPTH - 1));
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
        in_ready <= 1'b1;
      end
    end
  end
endmodule

// ==========================================
// host port top
module ttp_host_port #(
  parameter int BURST_CYC = `TTP_BURST_CYC,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host bus pins
  input wire logic register_select_line,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_oe,
  // open-drain interrupt pin
  output logic interrupt_or_progress_out,
  output logic interrupt_or_progress_oe,
  // call progress square wave from receive filter
  input wire logic cp_wave,
  // decoder side
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [3:0] rx_digit,
  input wire logic tone_pair_seen,
  input wire logic tone_absent_seen,
  // tone generator side
  output logic tone_on,
  output logic [3:0] tone_digit,
  output logic [3:0] tone_cfg
);
  localparam int CW = $clog2(2 * BURST_CYC + 1);

  // ==========================================
  // reset and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_l;
  ttp_pkg::ttp_pins_t pins_in;
  ttp_pkg::ttp_pins_t sync1_q;
  ttp_pkg::ttp_pins_t sync2_q;
  ttp_pkg::ttp_pins_t prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_l = rst_sync_q[1];

  assign pins_in = '{rs: register_select_line, rd_n: rd_n, wr_n: wr_n,
                     data: data_in, cp_wave: cp_wave};

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      sync1_q <= '{rs: 1'b0, rd_n: 1'b1, wr_n: 1'b1, data: 4'h0, cp_wave: 1'b0};
      sync2_q <= '{rs: 1'b0, rd_n: 1'b1, wr_n: 1'b1, data: 4'h0, cp_wave: 1'b0};
      prev_q <= '{rs: 1'b0, rd_n: 1'b1, wr_n: 1'b1, data: 4'h0, cp_wave: 1'b0};
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // ==========================================
  // strobe decode
  logic rd_active;
  logic rd_done;
  logic wr_done;
  logic stat_read;
  logic ctrl_write;
  logic tx_write;
  logic rx_read;

  assign rd_active = !sync2_q.rd_n;
  assign rd_done = !prev_q.rd_n && sync2_q.rd_n;
  assign wr_done = !prev_q.wr_n && sync2_q.wr_n;
  assign stat_read = rd_done && prev_q.rs; // RL11
  assign rx_read = rd_done && !prev_q.rs; // RL11
  assign ctrl_write = wr_done && prev_q.rs; // RL11
  assign tx_write = wr_done && !prev_q.rs; // RL11

  // ==========================================
  // control registers
  logic [3:0] ctrl_a_q;
  logic [3:0] ctrl_b_q;
  logic sel_b_q;
  logic burst_on;
  logic ext_burst;

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      ctrl_a_q <= `TTP_CTRL_RST;
      ctrl_b_q <= `TTP_CTRL_RST;
      sel_b_q <= 1'b0;
    end else if (ctrl_write) begin
      if (sel_b_q) begin
        ctrl_b_q <= prev_q.data;
        sel_b_q <= 1'b0; // RL19
      end else begin
        ctrl_a_q <= prev_q.data;
        sel_b_q <= prev_q.data[`TTP_CA_NEXT_SEL]; // RL19
      end
    end
  end

  assign burst_on = !ctrl_b_q[`TTP_CB_NOBURST]; // RL21
  assign ext_burst = ctrl_a_q[`TTP_CA_CP];

  // ==========================================
  // burst transmitter
  ttp_pkg::ttp_tx_state_t tx_state_q;
  logic [CW-1:0] tx_cnt_q;
  logic [CW-1:0] phase_len;
  logic pause_end;

  assign phase_len = ext_burst ? CW'(2 * BURST_CYC) : CW'(BURST_CYC); // RL15
  assign pause_end = (tx_state_q == ttp_pkg::TTP_PAUSE) && (tx_cnt_q == CW'(1));

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      tx_state_q <= ttp_pkg::TTP_IDLE;
      tx_cnt_q <= '0;
      tone_digit <= 4'h0;
    end else if (!burst_on) begin
      tx_state_q <= ttp_pkg::TTP_IDLE;
      tx_cnt_q <= '0;
      if (tx_write) begin
        tone_digit <= prev_q.data;
      end
    end else begin
      case (tx_state_q)
        ttp_pkg::TTP_IDLE: begin
          if (tx_write) begin
            tone_digit <= prev_q.data;
            tx_state_q <= ttp_pkg::TTP_TONE;
            tx_cnt_q <= phase_len; // RL23
          end
        end
        ttp_pkg::TTP_TONE: begin
          if (tx_cnt_q == CW'(1)) begin
            tx_state_q <= ttp_pkg::TTP_PAUSE; // RL13
            tx_cnt_q <= phase_len;
          end else begin
            tx_cnt_q <= tx_cnt_q - 1'b1; // RL23
          end
        end
        ttp_pkg::TTP_PAUSE: begin
          if (tx_cnt_q == CW'(1)) begin
            tx_state_q <= ttp_pkg::TTP_IDLE; // RL14
            tx_cnt_q <= '0;
          end else begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
          end
        end
        default: begin
          tx_state_q <= ttp_pkg::TTP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      tone_on <= 1'b0;
      tone_cfg <= 4'h0;
    end else begin
      tone_cfg <= ctrl_b_q;
      if (burst_on) begin
        tone_on <= ctrl_a_q[`TTP_CA_TONE] && (tx_state_q == ttp_pkg::TTP_TONE); // RL13
      end else begin
        tone_on <= ctrl_a_q[`TTP_CA_TONE];
      end
    end
  end

  // ==========================================
  // receive buffer and data register
  logic fifo_valid;
  logic [3:0] fifo_data;
  logic rdr_full_q;
  logic [3:0] rdr_q;
  logic rdr_load;

  ttp_fifo #(
    .WIDTH(4),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(rst_l),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_digit),
    .out_valid(fifo_valid),
    .out_ready(rdr_load),
    .out_data(fifo_data)
  );

  assign rdr_load = fifo_valid && (!rdr_full_q || rx_read);

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      rdr_full_q <= 1'b0;
      rdr_q <= 4'h0;
    end else if (rdr_load) begin
      rdr_full_q <= 1'b1;
      rdr_q <= fifo_data;
    end else if (rx_read) begin
      rdr_full_q <= 1'b0;
    end
  end

  // ==========================================
  // status flags, set wins over clear
  ttp_pkg::ttp_status_t stat_q;
  logic txe_set;
  logic rxf_set;

  assign txe_set = burst_on && pause_end; // RL3
  assign rxf_set = rdr_load; // RL5

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      stat_q <= `TTP_STAT_RST;
    end else begin
      if (txe_set) begin
        stat_q.tx_empty <= 1'b1; // RL3
      end else if (stat_read || !burst_on) begin
        stat_q.tx_empty <= 1'b0; // RL4
      end
      if (rxf_set) begin
        stat_q.rx_full <= 1'b1; // RL5
      end else if (stat_read) begin
        stat_q.rx_full <= 1'b0; // RL6
      end
      if (txe_set || rxf_set) begin
        stat_q.irq <= 1'b1; // RL1
      end else if (stat_read) begin
        stat_q.irq <= 1'b0; // RL2
      end
      if (tone_absent_seen) begin
        stat_q.steer <= 1'b1; // RL7
      end else if (tone_pair_seen) begin
        stat_q.steer <= 1'b0; // RL8
      end
    end
  end

  // ==========================================
  // read data and interrupt pin
  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      data_out <= 4'h0;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_active;
      if (sync2_q.rs) begin
        data_out <= stat_q; // RL11
      end else begin
        data_out <= rdr_q; // RL11
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      interrupt_or_progress_out <= 1'b0;
      interrupt_or_progress_oe <= 1'b0;
    end else begin
      interrupt_or_progress_out <= 1'b0;
      if (!ctrl_a_q[`TTP_CA_IRQEN]) begin
        interrupt_or_progress_oe <= 1'b0;
      end else if (ctrl_a_q[`TTP_CA_CP]) begin
        interrupt_or_progress_oe <= !sync2_q.cp_wave;
      end else if (ctrl_b_q[`TTP_CB_TEST]) begin
        interrupt_or_progress_oe <= !stat_q.steer;
      end else begin
        interrupt_or_progress_oe <= stat_q.irq; // RL20 RL22
      end
    end
  end
endmodule

// File: tb/ttp_monitor.sv
`timescale 1ns/1ns
// ==========================================
// port checker
module ttp_monitor #(parameter int BURST_CYC = 50) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host pins
  input wire logic register_select_line,
  input wire logic rd_n,
  input wire logic data_oe,
  input wire logic interrupt_or_progress_out,
  input wire logic interrupt_or_progress_oe,
  // tone side
  input wire logic tone_on,
  input wire logic [3:0] tone_digit,
  input wire logic [3:0] tone_cfg
);
  int ton_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ton_q <= 0;
    else ton_q <= tone_on ? ton_q + 1 : 0;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_od_value: assert property (!interrupt_or_progress_out)
    else $error("irq pin value not low");
  a_read_drive: assert property ($fell(rd_n) |-> ##[2:4] data_oe)
    else $error("read not answered");
  a_read_release: assert property ($rose(rd_n) |-> ##[2:4] !data_oe)
    else $error("data bus not released");
  a_drive_cause: assert property ($rose(data_oe) |-> !$past(rd_n, 2) && !rd_n)
    else $error("data driven without read");
  a_oe_hold: assert property (data_oe && !rd_n |=> data_oe)
    else $error("read data dropped early");
  a_irq_release: assert property ($rose(rd_n) && register_select_line && !tone_cfg[1]
    |-> ##[3:6] !interrupt_or_progress_oe)
    else $error("irq pin kept after status read");
  a_cfg_by_write: assert property ($changed(tone_cfg) |-> $past(register_select_line, 2))
    else $error("control changed without control write");
  a_digit_by_write: assert property ($changed(tone_digit) |-> !$past(register_select_line, 2))
    else $error("digit changed without data write");
  a_tone_length: assert property ($fell(tone_on) && !tone_cfg[0] |-> ton_q inside
    {[BURST_CYC - 2:BURST_CYC + 2], [2 * BURST_CYC - 2:2 * BURST_CYC + 2]})
    else $error("tone burst length wrong");
  c_burst: cover property ($fell(tone_on));
  c_irq: cover property ($rose(interrupt_or_progress_oe));
  c_read: cover property ($rose(data_oe) && register_select_line);
endmodule

bind ttp_host_port ttp_monitor #(.BURST_CYC(BURST_CYC)) mon_u (.ref_clk(ref_clk),
  .rst_n(rst_n), .register_select_line(register_select_line), .rd_n(rd_n),
  .data_oe(data_oe), .interrupt_or_progress_out(interrupt_or_progress_out),
  .interrupt_or_progress_oe(interrupt_or_progress_oe), .tone_on(tone_on),
  .tone_digit(tone_digit), .tone_cfg(tone_cfg));

// File: tb/ttp_host_model.sv
`timescale 1ns/1ns
// ==========================================
// host processor on the parallel bus
module ttp_host_model (
  // clock
  input wire logic ref_clk,
  // bus pins
  output logic register_select_line,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] data_in,
  // read answer
  input wire logic [3:0] data_out,
  input wire logic data_oe
);
  initial begin
    register_select_line = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 4'h0;
  end
  task automatic hold(int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic wr(logic rs, logic [3:0] d);
    hold(1);
    register_select_line = rs;
    data_in = d;
    hold(1);
    wr_n = 1'b0;
    hold(4);
    wr_n = 1'b1;
    hold(5);
    data_in = ~d;
  endtask
  task automatic rd(logic rs);
    int n;
    hold(1);
    register_select_line = rs;
    hold(1);
    rd_n = 1'b0;
    n = 0;
    while (data_oe !== 1'b1 && n < 20) begin
      hold(1);
      n++;
    end
    hold(1);
    rd_n = 1'b1;
    hold(5);
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int BC = 50;
  logic ref_clk, rst_n, cp_wave, rx_valid, tone_pair_seen, tone_absent_seen;
  logic rs, rd_n, wr_n, data_oe, irq_out, irq_oe, rx_ready, tone_on, oe_q, ton_q;
  logic [3:0] rx_digit, data_in, data_out, tone_digit, tone_cfg;
  logic [3:0] exp_q[$];
  logic [3:0] rxd_q[$];
  int bad_count, comparisons, cyc, n, age;
  ttp_host_port #(.BURST_CYC(BC), .FIFO_DEPTH(32)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .register_select_line(rs), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .interrupt_or_progress_out(irq_out),
    .interrupt_or_progress_oe(irq_oe), .cp_wave(cp_wave), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_digit(rx_digit), .tone_pair_seen(tone_pair_seen),
    .tone_absent_seen(tone_absent_seen), .tone_on(tone_on), .tone_digit(tone_digit),
    .tone_cfg(tone_cfg));
  ttp_host_model host_u (.ref_clk(ref_clk), .register_select_line(rs), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // ==========================================
  // checks and watchers
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic sread(logic [3:0] e);
    exp_q.push_back(e);
    host_u.rd(1'b1);
  endtask
  task automatic til(int a);
    while (age < a) @(negedge ref_clk);
  endtask
  task automatic burst(logic [3:0] d, int t, logic e);
    host_u.wr(1'b0, d);
    chk(tone_digit, d);
    til(t - 14);
    sread(4'h0);
    til(t + 4);
    chk({3'h0, irq_oe}, {3'h0, e});
    chk({3'h0, irq_out}, 4'h0);
    sread(4'h3);
    chk({3'h0, irq_oe}, 4'h0);
    sread(4'h0);
  endtask
  always @(negedge ref_clk) begin
    oe_q <= data_oe;
    ton_q <= tone_on;
    age <= (tone_on === 1'b1 && ton_q !== 1'b1) ? 0 : age + 1;
    if (data_oe === 1'b1 && oe_q !== 1'b1) chk(data_out, exp_q.pop_front());
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 6000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    cp_wave = 1'b1;
    rx_valid = 1'b0;
    rx_digit = 4'h0;
    tone_pair_seen = 1'b0;
    tone_absent_seen = 1'b0;
    void'($urandom(85432));
    repeat (5) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    sread(4'h0);
    for (int i = 0; i < 5; i++) host_u.wr(1'b1, i == 3 ? 4'h8 : 4'h0);
    sread(4'h0);
    chk(tone_cfg, 4'h0);
    host_u.wr(1'b1, 4'h8);
    host_u.wr(1'b1, 4'hc);
    chk(tone_cfg, 4'hc);
    host_u.wr(1'b1, 4'h0);
    chk(tone_cfg, 4'hc);
    host_u.wr(1'b1, 4'hd);
    host_u.wr(1'b1, 4'h0);
    burst(4'h7, 2 * BC, 1'b1);
    burst(4'h5, 2 * BC, 1'b1);
    host_u.wr(1'b1, 4'h7);
    burst(4'h9, 4 * BC, 1'b0);
    cp_wave = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
    chk({3'h0, irq_oe}, 4'h1);
    cp_wave = 1'b1;
    host_u.wr(1'b1, 4'h8);
    host_u.wr(1'b1, 4'h1);
    host_u.wr(1'b0, 4'h3);
    chk({3'h0, tone_on}, 4'h0);
    host_u.wr(1'b1, 4'h5);
    til(3 * BC);
    chk({3'h0, tone_on}, 4'h1);
    sread(4'h0);
    tone_absent_seen = 1'b1;
    @(posedge ref_clk);
    #2 tone_absent_seen = 1'b0;
    n = 0;
    rx_valid = 1'b1;
    rx_digit = 4'($urandom);
    while (n < 3) begin
      @(negedge ref_clk);
      if (rx_ready === 1'b1) begin
        rxd_q.push_back(rx_digit);
        n = 0;
      end else n++;
      @(posedge ref_clk);
      #2;
      if (n == 0) rx_digit = 4'($urandom);
    end
    rx_valid = 1'b0;
    rx_digit = ~rx_digit;
    chk(4'(rxd_q.size() == 33), 4'h1);
    while (rxd_q.size() > 0) begin
      sread(4'hd);
      exp_q.push_back(rxd_q.pop_front());
      host_u.rd(1'b0);
    end
    sread(4'h8);
    host_u.wr(1'b1, 4'hd);
    host_u.wr(1'b1, 4'h3);
    chk(tone_cfg, 4'h3);
    chk({3'h0, irq_oe}, 4'h0);
    tone_pair_seen = 1'b1;
    @(posedge ref_clk);
    #2 tone_pair_seen = 1'b0;
    @(posedge ref_clk);
    #2;
    chk({3'h0, irq_oe}, 4'h1);
    sread(4'h0);
    complete_run();
  end
endmodule
